// *** verilog/dio_pkg.sv ***
// Register map, fields and mode codes of the digital I/O port.
package dio_pkg;
    // Number of signal pins on the port.
    localparam int unsigned DIO_NPINS = 7;
    // Index of the external trigger pin (pin 4, counted from one).
    localparam int unsigned DIO_TRIG_PIN = 3;
    // Register byte offsets.
    localparam logic [7:0] DIO_CTRL_OFS = 8'h00;
    localparam logic [7:0] DIO_STAT_OFS = 8'h04;
    localparam logic [7:0] DIO_PINCFG_OFS = 8'h10;
    localparam logic [7:0] DIO_PERIOD_OFS = 8'h40;
    localparam logic [7:0] DIO_DUTY_OFS = 8'h60;
    // Control register fields.
    localparam int unsigned DIO_CTRL_ACT_BIT = 0;
    localparam int unsigned DIO_CTRL_TRIG_BIT = 1;
    localparam int unsigned DIO_CTRL_FCLR_BIT = 2;
    localparam int unsigned DIO_CTRL_FEN_LSB = 8;
    // Status register fields.
    localparam int unsigned DIO_STAT_IN_LSB = 0;
    localparam int unsigned DIO_STAT_FAULT_BIT = 8;
    // Pin configuration fields.
    localparam int unsigned DIO_CFG_MODE_LSB = 0;
    localparam int unsigned DIO_CFG_INV_BIT = 2;
    localparam int unsigned DIO_CFG_PWM_BIT = 3;
    localparam int unsigned DIO_CFG_VAL_BIT = 4;
    // Widths of the PWM settings.
    localparam int unsigned DIO_PER_W = 24;
    localparam int unsigned DIO_DUTY_W = 7;
    // Full scale of the duty setting, in percent.
    localparam logic [DIO_DUTY_W-1:0] DIO_DUTY_FULL = 7'h64;
    // Reset values.
    localparam logic [DIO_PER_W-1:0] DIO_PER_RST = 24'h000000;
    localparam logic [DIO_DUTY_W-1:0] DIO_DUTY_RST = 7'h00;
    // Pin mode selection.
    typedef enum logic [1:0] {
        DIO_MODE_CUSTOM = 2'h0,
        DIO_MODE_INPUT = 2'h1,
        DIO_MODE_OUTPUT = 2'h2
    } dio_mode_t;
    // Action taken on an external fault.
    typedef enum logic {
        DIO_ACT_ZERO = 1'b0,
        DIO_ACT_OFF = 1'b1
    } dio_act_t;
    // APB slave phases.
    typedef enum logic {
        DIO_BUS_IDLE,
        DIO_BUS_ANSWER
    } dio_bus_t;
endpackage : dio_pkg

// *** verilog/dio_pwm_if.sv ***
// One pin's PWM settings and waveform.
`timescale 1ns/10ps
`default_nettype none
interface dio_pwm_if;
    import dio_pkg::*;
    logic [DIO_PER_W-1:0] period; // Period in clock cycles.
    logic [DIO_DUTY_W-1:0] duty; // Duty cycle in percent.
    logic wave; // Logical waveform, true during the duty part.
    modport src (output period, output duty, input wave);
    modport gen (input period, input duty, output wave);
endinterface : dio_pwm_if
`default_nettype wire

// *** verilog/dio_pwm.sv ***
// PWM generator: period counter and duty threshold.
`timescale 1ns/10ps
`default_nettype none
module dio_pwm (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    dio_pwm_if.gen pwm
);
    import dio_pkg::*;
    logic [DIO_PER_W-1:0] cnt_ff; // Position inside the period.
    logic [DIO_PER_W-1:0] nxt_cnt;
    logic wave_ff; // Registered waveform.
    logic nxt_wave;
    logic [31:0] lhs; // Count scaled by full duty.
    logic [31:0] rhs; // Period scaled by duty.

    // Counter wraps at the period; wave is true below the threshold.
    always_comb begin
        lhs = 32'(cnt_ff) * 32'(DIO_DUTY_FULL);
        rhs = 32'(pwm.period) * 32'(pwm.duty);
        if (cnt_ff + 24'h000001 >= pwm.period) begin
            nxt_cnt = '0;
        end else begin
            nxt_cnt = cnt_ff + 24'h000001;
        end
        nxt_wave = (pwm.period != '0) && (lhs < rhs);
    end

    // Registers of the generator.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt_ff <= '0;
            wave_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            wave_ff <= nxt_wave;
        end
    end

    assign pwm.wave = wave_ff;
endmodule : dio_pwm
`default_nettype wire

// *** verilog/dio_in_cell.sv ***
// Input cell: polarity and high-to-low pulses of one pin.
`timescale 1ns/10ps
`default_nettype none
module dio_in_cell (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic level_i,
    input wire logic invert_i,
    output logic value_o,
    output logic fall_o
);
    logic lvl_ff; // Last pin level, idles high.
    logic nxt_lvl;
    logic fall_ff; // One-cycle pulse on a high-to-low pin edge.
    logic nxt_fall;

    // Edge detect on the pin level.
    always_comb begin
        nxt_lvl = level_i;
        nxt_fall = lvl_ff & ~level_i;
    end

    // Registers of the cell.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            lvl_ff <= 1'b1;
            fall_ff <= 1'b0;
        end else begin
            lvl_ff <= nxt_lvl;
            fall_ff <= nxt_fall;
        end
    end

    assign value_o = lvl_ff ^ invert_i;
    assign fall_o = fall_ff;
endmodule : dio_in_cell
`default_nettype wire

// *** verilog/dio_port_top.sv ***
// Seven-pin digital I/O port with its APB registers.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Seven two-way pins sharing one ground.
// - Per pin mode: custom, input or output.
// - General input and output identical on all pins.
// - Normal polarity: true drives low, false high; custom mode drives true high.
// - Inverted polarity: true drives high, false low; custom mode drives true low.
// - PWM output uses per-pin frequency and duty.
// - Every pulse is a high-to-low transition.
// - Fault input zeroes setpoint or switches input off.
// - External trigger source uses pin four.
// - Open input reads one, or zero inverted.
module dio_port_top (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Pins: level seen, level driven, drive enable.
    input wire logic [dio_pkg::DIO_NPINS-1:0] pin_i,
    output logic [dio_pkg::DIO_NPINS-1:0] pin_o,
    output logic [dio_pkg::DIO_NPINS-1:0] pin_oe_o,
    // Custom functions of the instrument core.
    input wire logic [dio_pkg::DIO_NPINS-1:0] custom_out_i,
    input wire logic [dio_pkg::DIO_NPINS-1:0] custom_oe_i,
    output logic [dio_pkg::DIO_NPINS-1:0] custom_in_o,
    output logic [dio_pkg::DIO_NPINS-1:0] custom_fall_o,
    // Trigger and fault results.
    output logic ext_trig_o,
    output logic setpoint_zero_o,
    output logic input_off_o
);
    import dio_pkg::*;

    // Pin index of a per-pin register block, or a miss.
    function automatic logic [3:0] pin_hit(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        if (addr >= base && diff[1:0] == 2'h0 && diff[7:2] < 6'(DIO_NPINS)) begin
            pin_hit = {1'b1, diff[4:2]};
        end else begin
            pin_hit = 4'h0;
        end
    endfunction : pin_hit

    // Bus state.
    dio_bus_t bus_ff;
    dio_bus_t nxt_bus;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;

    // Software configuration.
    dio_act_t act_ff; // Fault action.
    dio_act_t nxt_act;
    logic trig_en_ff; // External trigger source selected.
    logic nxt_trig_en;
    logic [DIO_NPINS-1:0] fen_ff; // Pins used as fault inputs.
    logic [DIO_NPINS-1:0] nxt_fen;
    dio_mode_t mode_ff [DIO_NPINS]; // Per-pin mode.
    dio_mode_t nxt_mode [DIO_NPINS];
    logic [DIO_NPINS-1:0] inv_ff; // Per-pin polarity.
    logic [DIO_NPINS-1:0] nxt_inv;
    logic [DIO_NPINS-1:0] pwm_ff; // Output kind: static or PWM.
    logic [DIO_NPINS-1:0] nxt_pwm;
    logic [DIO_NPINS-1:0] val_ff; // Static logical output value.
    logic [DIO_NPINS-1:0] nxt_val;
    logic [DIO_PER_W-1:0] per_ff [DIO_NPINS]; // PWM period in cycles.
    logic [DIO_PER_W-1:0] nxt_per [DIO_NPINS];
    logic [DIO_DUTY_W-1:0] duty_ff [DIO_NPINS]; // PWM duty in percent.
    logic [DIO_DUTY_W-1:0] nxt_duty [DIO_NPINS];

    // Pin side state.
    logic fault_ff; // Sticky fault, cleared by software.
    logic nxt_fault;
    logic [DIO_NPINS-1:0] pin_o_ff;
    logic [DIO_NPINS-1:0] nxt_pin_o;
    logic [DIO_NPINS-1:0] pin_oe_ff;
    logic [DIO_NPINS-1:0] nxt_pin_oe;
    logic [DIO_NPINS-1:0] cin_ff;
    logic [DIO_NPINS-1:0] cfall_ff;
    logic trig_ff;
    logic nxt_trig;
    logic zero_ff;
    logic off_ff;

    // Per-pin helpers.
    logic [DIO_NPINS-1:0] in_val; // Logical input values.
    logic [DIO_NPINS-1:0] in_fall; // High-to-low pulses.
    logic [DIO_NPINS-1:0] wave; // PWM logical waveforms.
    logic [DIO_NPINS-1:0] fault_hit; // Fault seen on an input pin.
    logic acc; // Access phase taken this cycle.
    logic [3:0] hit_cfg;
    logic [3:0] hit_per;
    logic [3:0] hit_duty;

    // One input cell and one PWM generator per pin.
    generate
        for (genvar gi = 0; gi < DIO_NPINS; gi++) begin : g_pin
            dio_pwm_if pwm_if ();
            assign pwm_if.period = per_ff[gi];
            assign pwm_if.duty = duty_ff[gi];
            assign wave[gi] = pwm_if.wave;
            dio_pwm u_pwm (
                .ref_clk_i(ref_clk_i),
                .srst_i(srst_i),
                .pwm(pwm_if)
            );
            dio_in_cell u_in (
                .ref_clk_i(ref_clk_i),
                .srst_i(srst_i),
                .level_i(pin_i[gi]),
                .invert_i(inv_ff[gi]),
                .value_o(in_val[gi]),
                .fall_o(in_fall[gi])
            );
        end
    endgenerate

    // Register decode, writes and read data, ready one access cycle late.
    always_comb begin
        acc = psel_i && penable_i && (bus_ff == DIO_BUS_IDLE);
        hit_cfg = pin_hit(paddr_i, DIO_PINCFG_OFS);
        hit_per = pin_hit(paddr_i, DIO_PERIOD_OFS);
        hit_duty = pin_hit(paddr_i, DIO_DUTY_OFS);
        nxt_bus = acc ? DIO_BUS_ANSWER : DIO_BUS_IDLE;
        nxt_pready = acc;
        nxt_pslverr = 1'b0;
        nxt_prdata = '0;
        nxt_act = act_ff;
        nxt_trig_en = trig_en_ff;
        nxt_fen = fen_ff;
        nxt_mode = mode_ff;
        nxt_inv = inv_ff;
        nxt_pwm = pwm_ff;
        nxt_val = val_ff;
        nxt_per = per_ff;
        nxt_duty = duty_ff;
        nxt_fault = fault_ff | (|fault_hit);
        if (acc) begin
            if (paddr_i == DIO_CTRL_OFS) begin
                nxt_prdata[DIO_CTRL_ACT_BIT] = act_ff;
                nxt_prdata[DIO_CTRL_TRIG_BIT] = trig_en_ff;
                nxt_prdata[DIO_CTRL_FEN_LSB +: DIO_NPINS] = fen_ff;
                if (pwrite_i) begin
                    nxt_act = dio_act_t'(pwdata_i[DIO_CTRL_ACT_BIT]);
                    nxt_trig_en = pwdata_i[DIO_CTRL_TRIG_BIT];
                    nxt_fen = pwdata_i[DIO_CTRL_FEN_LSB +: DIO_NPINS];
                    // A fault in the same cycle beats the clear.
                    if (pwdata_i[DIO_CTRL_FCLR_BIT] && !(|fault_hit)) begin
                        nxt_fault = 1'b0;
                    end
                end
            end else if (paddr_i == DIO_STAT_OFS) begin
                nxt_prdata[DIO_STAT_IN_LSB +: DIO_NPINS] = in_val;
                nxt_prdata[DIO_STAT_FAULT_BIT] = fault_ff;
            end else if (hit_cfg[3]) begin
                nxt_prdata[DIO_CFG_MODE_LSB +: 2] = mode_ff[hit_cfg[2:0]];
                nxt_prdata[DIO_CFG_INV_BIT] = inv_ff[hit_cfg[2:0]];
                nxt_prdata[DIO_CFG_PWM_BIT] = pwm_ff[hit_cfg[2:0]];
                nxt_prdata[DIO_CFG_VAL_BIT] = val_ff[hit_cfg[2:0]];
                if (pwrite_i) begin
                    // Code three is no mode and falls back to custom.
                    if (pwdata_i[DIO_CFG_MODE_LSB +: 2] == 2'h3) begin
                        nxt_mode[hit_cfg[2:0]] = DIO_MODE_CUSTOM;
                    end else begin
                        nxt_mode[hit_cfg[2:0]] = dio_mode_t'(pwdata_i[DIO_CFG_MODE_LSB +: 2]);
                    end
                    nxt_inv[hit_cfg[2:0]] = pwdata_i[DIO_CFG_INV_BIT];
                    nxt_pwm[hit_cfg[2:0]] = pwdata_i[DIO_CFG_PWM_BIT];
                    nxt_val[hit_cfg[2:0]] = pwdata_i[DIO_CFG_VAL_BIT];
                end
            end else if (hit_per[3]) begin
                nxt_prdata[DIO_PER_W-1:0] = per_ff[hit_per[2:0]];
                if (pwrite_i) begin
                    nxt_per[hit_per[2:0]] = pwdata_i[DIO_PER_W-1:0];
                end
            end else if (hit_duty[3]) begin
                nxt_prdata[DIO_DUTY_W-1:0] = duty_ff[hit_duty[2:0]];
                if (pwrite_i) begin
                    // Duty above full scale is clipped.
                    if (pwdata_i[DIO_DUTY_W-1:0] > DIO_DUTY_FULL) begin
                        nxt_duty[hit_duty[2:0]] = DIO_DUTY_FULL;
                    end else begin
                        nxt_duty[hit_duty[2:0]] = pwdata_i[DIO_DUTY_W-1:0];
                    end
                end
            end else begin
                nxt_pslverr = 1'b1; // Unmapped address.
            end
        end
    end

    // Pin drivers and fault, same for every pin, and the pin-four trigger.
    always_comb begin
        for (int i = 0; i < DIO_NPINS; i++) begin
            unique case (mode_ff[i])
                DIO_MODE_OUTPUT: begin
                    nxt_pin_oe[i] = 1'b1;
                    // Logical true drives low unless inverted.
                    nxt_pin_o[i] = ~((pwm_ff[i] ? wave[i] : val_ff[i]) ^ inv_ff[i]);
                end
                DIO_MODE_INPUT: begin
                    nxt_pin_oe[i] = 1'b0;
                    nxt_pin_o[i] = 1'b1;
                end
                DIO_MODE_CUSTOM: begin
                    nxt_pin_oe[i] = custom_oe_i[i];
                    nxt_pin_o[i] = custom_out_i[i] ^ inv_ff[i];
                end
            endcase
            // Fault is an enabled input at logical zero.
            fault_hit[i] = fen_ff[i] && (mode_ff[i] == DIO_MODE_INPUT) && !in_val[i];
        end
        // Pin-four pulse triggers when the external source is chosen and pin four is in custom mode.
        nxt_trig = trig_en_ff && (mode_ff[DIO_TRIG_PIN] == DIO_MODE_CUSTOM)
                   && (inv_ff[DIO_TRIG_PIN] ? (~cin_ff[DIO_TRIG_PIN] & in_val[DIO_TRIG_PIN])
                                             : in_fall[DIO_TRIG_PIN]);
    end

    // Registers of bus, configuration and pins.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bus_ff <= DIO_BUS_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
            act_ff <= DIO_ACT_ZERO;
            trig_en_ff <= 1'b0;
            fen_ff <= '0;
            inv_ff <= '0;
            pwm_ff <= '0;
            val_ff <= '0;
            for (int i = 0; i < DIO_NPINS; i++) begin
                mode_ff[i] <= DIO_MODE_CUSTOM;
                per_ff[i] <= DIO_PER_RST;
                duty_ff[i] <= DIO_DUTY_RST;
            end
            fault_ff <= 1'b0;
            pin_o_ff <= '1;
            pin_oe_ff <= '0;
            cin_ff <= '1;
            cfall_ff <= '0;
            trig_ff <= 1'b0;
            zero_ff <= 1'b0;
            off_ff <= 1'b0;
        end else begin
            bus_ff <= nxt_bus;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            act_ff <= nxt_act;
            trig_en_ff <= nxt_trig_en;
            fen_ff <= nxt_fen;
            mode_ff <= nxt_mode;
            inv_ff <= nxt_inv;
            pwm_ff <= nxt_pwm;
            val_ff <= nxt_val;
            per_ff <= nxt_per;
            duty_ff <= nxt_duty;
            fault_ff <= nxt_fault;
            pin_o_ff <= nxt_pin_o;
            pin_oe_ff <= nxt_pin_oe;
            cin_ff <= in_val;
            cfall_ff <= in_fall;
            trig_ff <= nxt_trig;
            zero_ff <= nxt_fault && (act_ff == DIO_ACT_ZERO);
            off_ff <= nxt_fault && (act_ff == DIO_ACT_OFF);
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign pin_o = pin_o_ff;
    assign pin_oe_o = pin_oe_ff;
    assign custom_in_o = cin_ff;
    assign custom_fall_o = cfall_ff;
    assign ext_trig_o = trig_ff;
    assign setpoint_zero_o = zero_ff;
    assign input_off_o = off_ff;
endmodule : dio_port_top
`default_nettype wire

// *** verification/dio_port_top_assertions.sv ***
// Checker of the digital I/O port top.
`timescale 1ns/10ps
`default_nettype none
module dio_port_chk (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [dio_pkg::DIO_NPINS-1:0] pin_i,
    input wire logic [dio_pkg::DIO_NPINS-1:0] pin_oe_o,
    input wire logic [dio_pkg::DIO_NPINS-1:0] custom_oe_i,
    input wire logic [dio_pkg::DIO_NPINS-1:0] custom_fall_o,
    input wire logic ext_trig_o,
    input wire logic setpoint_zero_o,
    input wire logic input_off_o
);
    import dio_pkg::*;
    logic cfg_wr_ff, nxt_cfg_wr; // Set by a pin config write.
    logic [3:0] age_ff, nxt_age; // Cycles since pin 4 changed.
    logic pin4_ff, nxt_pin4; // Pin 4 level one cycle ago.
    // Helper state, reset folded into next values.
    always_comb begin
        nxt_cfg_wr = !srst_i && (cfg_wr_ff || (psel_i && penable_i && pwrite_i && pready_o
            && paddr_i >= DIO_PINCFG_OFS && paddr_i < DIO_PERIOD_OFS));
        nxt_pin4 = pin_i[DIO_TRIG_PIN];
        nxt_age = (srst_i || pin_i[DIO_TRIG_PIN] != pin4_ff) ? 4'h0 : age_ff + 4'(age_ff != 4'hF);
    end
    // Registers the helper state.
    always_ff @(posedge ref_clk_i) begin
        cfg_wr_ff <= nxt_cfg_wr;
        pin4_ff <= nxt_pin4;
        age_ff <= nxt_age;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // First cycle of an access phase.
    sequence s_access;
        psel_i && penable_i && !$past(penable_i);
    endsequence
    AST_WAIT_ONE: assert property (s_access |=> pready_o)
        else $error("ready late");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    AST_ERR_DATA: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("bad error response");
    AST_FALL_SEEN: assert property (($past(pin_i) & ~pin_i) != '0 |-> ##[1:3] custom_fall_o != '0)
        else $error("fall not reported");
    AST_FALL_ONCE: assert property ((custom_fall_o & $past(custom_fall_o)) == '0)
        else $error("fall pulse too long");
    AST_TRIG_CAUSE: assert property (ext_trig_o |-> age_ff inside {[4'h1:4'h6]})
        else $error("trigger without pin 4 edge");
    AST_TRIG_PULSE: assert property (ext_trig_o |=> !ext_trig_o)
        else $error("trigger too long");
    AST_ACT_ONE: assert property (!(setpoint_zero_o && input_off_o))
        else $error("both fault actions active");
    AST_CUSTOM_OE: assert property (!cfg_wr_ff && !$past(srst_i) |->
        pin_oe_o == $past(custom_oe_i)) else $error("custom enable not followed");
endmodule : dio_port_chk
`default_nettype wire

// *** verification/dio_ext_model.sv ***
// Model of the external instrument on the pins.
`timescale 1ns/10ps
`default_nettype none
module dio_ext_model (
    input wire logic ref_clk_i,
    input wire logic clr_i,
    input wire logic [dio_pkg::DIO_NPINS-1:0] drv_en_i,
    input wire logic [dio_pkg::DIO_NPINS-1:0] drv_lvl_i,
    input wire logic [dio_pkg::DIO_NPINS-1:0] pin_o_i,
    input wire logic [dio_pkg::DIO_NPINS-1:0] pin_oe_i,
    output logic [dio_pkg::DIO_NPINS-1:0] wire_o,
    output var int low_n [dio_pkg::DIO_NPINS]
);
    import dio_pkg::*;
    // Port drive wins, then ours, else pull-up high.
    always_comb begin
        for (int k = 0; k < DIO_NPINS; k++) begin
            wire_o[k] = pin_oe_i[k] ? pin_o_i[k] : (drv_en_i[k] ? drv_lvl_i[k] : 1'b1);
        end
    end
    // Counts low cycles, the active part of a pulse at normal polarity.
    always_ff @(posedge ref_clk_i) begin
        for (int k = 0; k < DIO_NPINS; k++) begin
            low_n[k] <= clr_i ? 0 : low_n[k] + int'(!wire_o[k]);
        end
    end
endmodule : dio_ext_model
`default_nettype wire

// *** verification/digital_io_port_config_bench.sv ***
// Self-checking bench of the digital I/O port.
`timescale 1ns/10ps
`default_nettype none
module digital_io_port_config_bench;
    import dio_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, trig, sp_zero, in_off;
    logic [6:0] pin_lvl, pin_o, pin_oe, cust_in, cust_fall;
    logic [6:0] cust_out = 7'h00;
    logic [6:0] cust_oe = 7'h00;
    logic [6:0] drv_en = 7'h00; // External drive enables.
    logic [6:0] drv_lvl = 7'h7F;
    logic clr = 1'b0;
    int low_n [DIO_NPINS];
    int miscompares = 0;
    int n_checks = 0;
    int seed = 21;
    logic [7:0] bases [3] = '{DIO_PINCFG_OFS, DIO_PERIOD_OFS, DIO_DUTY_OFS};
    int duty_tab [5] = '{0, 10, 50, 100, 37};
    dio_port_top i_dio_port_top (.ref_clk_i(clk), .srst_i(srst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pin_i(pin_lvl),
        .pin_o(pin_o), .pin_oe_o(pin_oe), .custom_out_i(cust_out), .custom_oe_i(cust_oe),
        .custom_in_o(cust_in), .custom_fall_o(cust_fall), .ext_trig_o(trig),
        .setpoint_zero_o(sp_zero), .input_off_o(in_off));
    dio_ext_model i_dio_ext_model (.ref_clk_i(clk), .clr_i(clr), .drv_en_i(drv_en),
        .drv_lvl_i(drv_lvl), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .wire_o(pin_lvl), .low_n(low_n));
    // Clock of 4 ns period.
    initial begin
        forever #2 clk = ~clk;
    end
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        n_checks++;
        if (got !== x) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, x, got);
        end
    endtask : chk
    // One APB transfer, answer taken at the edge with ready high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1) miscompares++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Expected readback of a stored value.
    function automatic logic [31:0] keep(input logic [7:0] a, input logic [31:0] d);
        if (a == DIO_CTRL_OFS) return d & 32'h7F03;
        if (a < DIO_PERIOD_OFS) return (d[1:0] == 2'h3) ? (d & 32'h1C) : (d & 32'h1F);
        if (a < DIO_DUTY_OFS) return d & 32'hFFFFFF;
        return (d[6:0] > 7'h64) ? 32'h64 : (d & 32'h7F);
    endfunction : keep
    // Ends the run with the verdict.
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog against a hang.
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        int v, per, act, n, f, pn;
        logic [7:0] a;
        logic [31:0] d;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("reset enable", 7'h00, pin_oe);
        chk("reset input", 7'h7F, cust_in);
        // Random custom drive in custom mode.
        repeat (20) begin
            @(posedge clk);
            cust_oe <= 7'($random(seed));
            cust_out <= 7'($random(seed));
        end
        @(posedge clk);
        cust_oe <= 7'h00;
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped error", 1'b1, e);
        apb(1'b1, DIO_CTRL_OFS, 32'($random(seed)) | 32'h4);
        apb(1'b0, DIO_CTRL_OFS, 32'h0);
        chk("control", 32'h0, q & 32'h4);
        // Reset values and random readback.
        for (int j = 0; j < 3; j++) begin
            for (int i = 0; i < 7; i++) begin
                a = bases[j] + 8'(4 * i);
                d = $random(seed);
                if (i == 0) d[1:0] = 2'h3;
                apb(1'b0, a, 32'h0);
                chk("reset value", 32'h0, q);
                apb(1'b1, a, d);
                apb(1'b0, a, 32'h0);
                chk("readback", keep(a, d), q);
                if (j == 0) apb(1'b1, a, 32'h0);
            end
        end
        apb(1'b1, DIO_CTRL_OFS, 32'h4);
        // Static output, both polarities.
        for (int i = 0; i < 28; i++) begin
            v = i / 7;
            apb(1'b1, DIO_PINCFG_OFS + 8'(4 * (i % 7)), 32'h2 + 32'((v % 2) * 4 + (v / 2) * 16));
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("drive enable", 1'b1, pin_oe[i % 7]);
            chk("pin level", 32'(v / 2 == v % 2), pin_lvl[i % 7]);
        end
        // General input, open or driven.
        apb(1'b1, DIO_STAT_OFS, 32'hFFFFFFFF);
        for (int p = 0; p < 7; p++) begin
            v = $random(seed);
            apb(1'b1, DIO_PINCFG_OFS + 8'(4 * p), 32'h1 + 32'(v[0]) * 4);
            @(posedge clk);
            drv_en[p] <= v[1];
            drv_lvl[p] <= v[2];
            repeat (3) @(posedge clk);
            apb(1'b0, DIO_STAT_OFS, 32'h0);
            chk("input value", (v[1] ? v[2] : 1'b1) ^ v[0], q[p]);
            chk("fault flag", 1'b0, q[8]);
            @(posedge clk);
            drv_en[p] <= 1'b0;
        end
        // PWM with random periods and boundary and fixed duties.
        for (int i = 0; i < 5; i++) begin
            per = 5 + ($random(seed) & 15);
            apb(1'b1, DIO_PERIOD_OFS + 8'(4 * i), 32'(per));
            apb(1'b1, DIO_DUTY_OFS + 8'(4 * i), 32'(duty_tab[i]));
            apb(1'b1, DIO_PINCFG_OFS + 8'(4 * i), 32'hA + 32'((i % 2) * 4));
            repeat (per) @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (3 * per) @(posedge clk);
            @(negedge clk);
            act = (per * duty_tab[i] + 99) / 100;
            chk("pwm low", 32'((i % 2) ? 3 * (per - act) : 3 * act), low_n[i]);
        end
        // Sticky fault on pin 2 with each action.
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, DIO_PINCFG_OFS + 8'h04, 32'h1);
            apb(1'b1, DIO_CTRL_OFS, 32'h200 + 32'(k));
            @(posedge clk);
            drv_en[1] <= 1'b1;
            drv_lvl[1] <= 1'b0;
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk("setpoint zero", k == 0, sp_zero);
            chk("input off", k == 1, in_off);
            @(posedge clk);
            drv_en[1] <= 1'b0;
            apb(1'b0, DIO_STAT_OFS, 32'h0);
            chk("sticky fault", 1'b1, q[8]);
            apb(1'b1, DIO_CTRL_OFS, 32'h204 + 32'(k));
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("cleared", 2'b00, {sp_zero, in_off});
        end
        // Trigger on pin 4 only, not on pin 1.
        apb(1'b1, DIO_PINCFG_OFS, 32'h0);
        apb(1'b1, DIO_PINCFG_OFS + 8'h0C, 32'h0);
        apb(1'b1, DIO_CTRL_OFS, 32'h2);
        for (int k = 0; k < 2; k++) begin
            pn = k ? 0 : DIO_TRIG_PIN;
            n = 0;
            f = 0;
            @(posedge clk);
            drv_en[pn] <= 1'b1;
            drv_lvl[pn] <= 1'b0;
            repeat (8) begin
                @(negedge clk);
                n += int'(trig);
                f += int'(cust_fall[pn]);
            end
            @(posedge clk);
            drv_en[pn] <= 1'b0;
            chk("trigger pulses", 32'(1 - k), 32'(n));
            chk("fall pulses", 32'h1, 32'(f));
            repeat (8) @(posedge clk);
        end
        tally_and_finish();
    end
endmodule : digital_io_port_config_bench
bind dio_port_top dio_port_chk i_dio_port_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_i(pin_i),
    .pin_oe_o(pin_oe_o), .custom_oe_i(custom_oe_i), .custom_fall_o(custom_fall_o),
    .ext_trig_o(ext_trig_o), .setpoint_zero_o(setpoint_zero_o), .input_off_o(input_off_o));
`default_nettype wire
